// file: hw/load_hold_judge.sv
`timescale 1ns/1ns
module load_hold_judge import hold_pkg::*; #(
  parameter int unsigned SAMPLE_DIV = SAMPLE_DIV_DEF,
  parameter int unsigned TENTH_CYC = MEAS_TENTH_CYC,
  parameter int unsigned HIST_DEPTH = 64
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // load samples
  input wire logic signed [15:0] load_in,
  // external pins
  input wire logic start_in,
  input wire logic hold_cmd_in,
  // judgment, completion and held value
  output judge_t judge_out,
  output logic judge_done_out,
  output logic meas_done_out,
  output logic signed [15:0] held_out
);
  localparam int unsigned HW = $clog2(HIST_DEPTH);

  // bus slave
  logic [31:0] ctrl_q;
  logic [31:0] cfg_q [WORKS][CFG_WORDS];
  logic wr_pend_q;
  logic rd_pend_q;
  logic addr_ok_q;
  logic [7:0] addr_q;
  logic [31:0] hrdata_q;
  logic hreadyout_q;
  logic hresp_q;
  logic [31:0] status_w;
  logic signed [15:0] pk_q;
  logic signed [15:0] vl_q;
  wire logic take = hsel & htrans[1] & hready;
  wire logic [3:0] act = ctrl_q[3:0];
  wire logic [3:0] edit = ctrl_q[11:8];
  wire logic cfg_hit = addr_q >= OFS_CFG_FIRST && addr_q <= OFS_CFG_LAST;
  wire logic [2:0] cfg_idx = 3'(addr_q[4:2] - 3'd1);
  wire logic [31:0] rd_mux = !addr_ok_q ? 32'h0000_0000
    : addr_q == OFS_CTRL ? ctrl_q
    : cfg_hit ? cfg_q[edit][cfg_idx]
    : addr_q == OFS_STATUS ? status_w
    : addr_q == OFS_EXTREMES ? {vl_q, pk_q} : 32'h0000_0000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_ok_q <= 1'b0;
      addr_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end else begin
      wr_pend_q <= take & hwrite & (hsize == 3'b010);
      rd_pend_q <= take & ~hwrite;
      hreadyout_q <= ~(take & ~hwrite);
      if (take) begin
        addr_q <= {haddr[7:2], 2'b00};
        addr_ok_q <= haddr[31:8] == 24'h00_0000;
      end
      if (rd_pend_q) begin
        hrdata_q <= rd_mux;
      end
    end
  end

  // per-work settings, edited through the edit index
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= CTRL_RST;
      for (int w = 0; w < WORKS; w++) begin
        for (int i = 0; i < CFG_WORDS; i++) begin
          cfg_q[w][i] <= CFG_RST[i];
        end
      end
    end else if (wr_pend_q && addr_ok_q) begin
      if (addr_q == OFS_CTRL) begin
        ctrl_q <= hwdata & CTRL_MASK;
      end else if (cfg_hit) begin
        cfg_q[edit][cfg_idx] <= hwdata & CFG_MASK[cfg_idx];
      end
    end
  end

  // active work drives the block; window A counts back from the window B point
  work_cfg_t cur;
  assign cur = {cfg_q[act][6], cfg_q[act][5], cfg_q[act][4], cfg_q[act][3],
    cfg_q[act][2], cfg_q[act][1], cfg_q[act][0]};

  // pin synchronisers; hold command must stay long enough to pass them
  logic [1:0] start_s_q;
  logic [1:0] hold_s_q;
  logic start_prev_q;
  logic hold_prev_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_s_q <= 2'b00;
      hold_s_q <= 2'b00;
      start_prev_q <= 1'b0;
      hold_prev_q <= 1'b0;
    end else begin
      start_s_q <= {start_s_q[0], start_in};
      hold_s_q <= {hold_s_q[0], hold_cmd_in};
      start_prev_q <= start_s_q[1];
      hold_prev_q <= hold_s_q[1];
    end
  end
  wire logic start_lvl = start_s_q[1];
  wire logic start_rise = start_s_q[1] & ~start_prev_q;
  wire logic hold_rise = hold_s_q[1] & ~hold_prev_q;

  // sample rate divider
  logic [15:0] div_q;
  wire logic tick = div_q == 16'(SAMPLE_DIV - 1);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= tick ? 16'h0000 : 16'(div_q + 16'h0001);
    end
  end

  // measuring period
  meas_state_t state_q;
  meas_state_t state_d;
  logic [24:0] tenth_q;
  logic [9:0] time_q;
  logic meas_done_q;
  logic judge_done_q;
  wire logic meas = state_q == ST_MEAS;
  wire logic tenth_end = tenth_q == 25'(TENTH_CYC - 1);
  wire logic [9:0] mt = cur.meas_time > 10'(MEAS_TIME_MAX) ? 10'(MEAS_TIME_MAX)
    : cur.meas_time == 10'h000 ? 10'h001 : cur.meas_time;
  wire logic time_end = tenth_end & (10'(time_q + 10'h001) >= mt);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: if (start_rise) state_d = ST_MEAS;
      ST_MEAS: if (!start_rise && (!start_lvl || time_end)) state_d = ST_JUDGE;
      ST_JUDGE: state_d = start_rise ? ST_MEAS : ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ST_IDLE;
      tenth_q <= 25'h000_0000;
      time_q <= 10'h000;
    end else begin
      state_q <= state_d;
      if (start_rise || state_d != ST_MEAS || tenth_end) begin
        tenth_q <= 25'h000_0000;
      end else begin
        tenth_q <= 25'(tenth_q + 25'h000_0001);
      end
      if (start_rise || state_d != ST_MEAS) begin
        time_q <= 10'h000;
      end else if (tenth_end && time_q < 10'(MEAS_TIME_MAX)) begin
        time_q <= 10'(time_q + 10'h001);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meas_done_q <= 1'b0;
      judge_done_q <= 1'b0;
    end else if (start_rise) begin
      meas_done_q <= 1'b0;
      judge_done_q <= 1'b0;
    end else if (state_q == ST_JUDGE) begin
      meas_done_q <= 1'b1;
      judge_done_q <= cur.crit_load;
    end
  end

  // slope-break history and detection
  logic signed [15:0] hist_q [HIST_DEPTH];
  logic [HW-1:0] ptr_q;
  logic arm_q;
  logic [5:0] fill_q;
  wire logic [HW-1:0] ib = HW'(ptr_q - HW'(cur.win_b));
  wire logic [HW-1:0] iba = HW'(ib - HW'(cur.win_a));
  wire logic signed [15:0] xb = hist_q[ib];
  wire logic signed [15:0] xba = hist_q[iba];
  wire logic signed [16:0] chg_c = 17'(xb) - 17'(xba);
  wire logic signed [16:0] chg_e = 17'(load_in) - 17'(xb);
  wire logic signed [17:0] chg_d = 18'(chg_e) - 18'(chg_c);
  wire logic [5:0] win_sum = 6'({1'b0, cur.win_a} + {1'b0, cur.win_b});
  wire logic slope_hit = arm_q & (fill_q >= win_sum)
    & (chg_d > 18'(cur.slope_change_threshold));

  always_ff @(posedge hclk) begin
    if (tick) begin
      hist_q[ptr_q] <= load_in;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ptr_q <= '0;
      arm_q <= 1'b0;
      fill_q <= 6'h00;
    end else begin
      if (tick) ptr_q <= HW'(ptr_q + 1'b1);
      if (start_rise) begin
        arm_q <= 1'b0;
        fill_q <= 6'h00;
      end else if (meas && tick) begin
        if (load_in > cur.detect_start) arm_q <= 1'b1;
        if (arm_q && fill_q != 6'h3f) fill_q <= 6'(fill_q + 6'h01);
      end
    end
  end

  // swing extremes
  logic first_q;
  wire logic [15:0] swing_slope_change_threshold = 16'(pk_q - vl_q);
  wire logic [23:0] swing_prod = swing_slope_change_threshold * cur.swing_scale;
  wire logic swing_hit = !first_q & (swing_prod > {8'h00, cur.swing_level});
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_q <= 1'b1;
      pk_q <= 16'sh0000;
      vl_q <= 16'sh0000;
    end else if (start_rise) begin
      first_q <= 1'b1;
    end else if (meas && tick) begin
      first_q <= 1'b0;
      pk_q <= (first_q || load_in > pk_q) ? load_in : pk_q;
      vl_q <= (first_q || load_in < vl_q) ? load_in : vl_q;
    end
  end

  // held value
  logic signed [15:0] held_q;
  logic signed [15:0] held_d;
  logic valid_q;
  logic valid_d;
  always_comb begin
    held_d = held_q;
    valid_d = valid_q;
    if (start_rise && cur.mode != HM_TRACK) begin
      held_d = 16'sh0000;
      valid_d = 1'b0;
    end else begin
      unique case (cur.mode)
        HM_TRACK: if (tick) begin
          held_d = load_in;
          valid_d = 1'b1;
        end
        HM_SAMPLE: if (meas && hold_rise && !valid_q) begin
          held_d = load_in;
          valid_d = 1'b1;
        end
        HM_PEAK: if (meas && tick && (!valid_q || load_in > held_q)) begin
          held_d = load_in;
          valid_d = 1'b1;
        end
        HM_SLOPE: if (meas && tick && !valid_q && slope_hit) begin
          held_d = xb;
          valid_d = 1'b1;
        end
        HM_SWING: if (meas && tick && (valid_q || swing_hit)) begin
          held_d = cur.swing_min ? vl_q : pk_q;
          valid_d = 1'b1;
        end
        default: valid_d = valid_q;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      held_q <= 16'sh0000;
      valid_q <= 1'b0;
    end else begin
      held_q <= held_d;
      valid_q <= valid_d;
    end
  end

  // judgment of the held value
  limits_t lim_w;
  judge_t judge_res;
  assign lim_w = {cur.upper_limit, cur.bottom_limit, cur.top_alarm_limit,
    cur.deep_alarm_limit, cur.deadband_width, cur.top_en, cur.deep_en, cur.const_judge};
  wire logic judge_upd = cur.crit_load & valid_q & ((state_q == ST_JUDGE)
    | (meas & cur.const_judge & tick));
  wire logic judge_clr = start_rise | ~cur.crit_load;

  limit_judge u_judge (
    .hclk(hclk),
    .hresetn(hresetn),
    .update(judge_upd),
    .clear(judge_clr),
    .value(held_q),
    .lim(lim_w),
    .res_q(judge_res)
  );

  assign status_w = {7'h00, state_q, valid_q, judge_done_q, meas_done_q, judge_res, held_q};
  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign judge_out = judge_res;
  assign judge_done_out = judge_done_q;
  assign meas_done_out = meas_done_q;
  assign held_out = held_q;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_track;
    cur.mode == HM_TRACK && tick |=> valid_q && held_q == $past(load_in);
  endproperty
  a_track: assert property (p_track) else $error("tracking value wrong");

  property p_sample_once;
    meas && cur.mode == HM_SAMPLE && valid_q && !start_rise |=> $stable(held_q);
  endproperty
  a_sample_once: assert property (p_sample_once) else $error("sample retaken");

  property p_sample_take;
    meas && cur.mode == HM_SAMPLE && hold_rise && !valid_q && !start_rise
      |=> valid_q && held_q == $past(load_in);
  endproperty
  a_sample_take: assert property (p_sample_take) else $error("sample not taken");

  property p_peak;
    meas && cur.mode == HM_PEAK && tick && valid_q && !start_rise |=> held_q >= $past(held_q);
  endproperty
  a_peak: assert property (p_peak) else $error("peak dropped");

  property p_slope_wait;
    meas && cur.mode == HM_SLOPE && !arm_q && !valid_q && !start_rise |=> !valid_q;
  endproperty
  a_slope_wait: assert property (p_slope_wait) else $error("slope held early");

  property p_slope_hold;
    meas && cur.mode == HM_SLOPE && tick && !valid_q && slope_hit && !start_rise
      |=> valid_q && held_q == $past(xb);
  endproperty
  a_slope_hold: assert property (p_slope_hold) else $error("slope point missed");

  property p_swing;
    meas && cur.mode == HM_SWING && tick && swing_hit && !start_rise |=> valid_q;
  endproperty
  a_swing: assert property (p_swing) else $error("swing not held");

  property p_start_clear;
    start_rise |=> !meas_done_q && !judge_done_q && judge_out == 4'h0 && meas;
  endproperty
  a_start_clear: assert property (p_start_clear) else $error("start did not clear");

  property p_done;
    state_q == ST_JUDGE && !start_rise |=> meas_done_q && judge_done_q == $past(cur.crit_load);
  endproperty
  a_done: assert property (p_done) else $error("completion not flagged");

  property p_time_cap;
    time_q <= 10'(MEAS_TIME_MAX) && (meas || time_q == 10'h000);
  endproperty
  a_time_cap: assert property (p_time_cap) else $error("measuring time over cap");

  property p_none;
    !cur.crit_load |=> judge_out == 4'h0;
  endproperty
  a_none: assert property (p_none) else $error("judged with criterion none");
endmodule : load_hold_judge

// file: hw/hold_pkg.sv
package hold_pkg;
  // timing
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned RESP_MAX_MS = 1;
  localparam int unsigned RESP_MAX_CYC = CLK_HZ / 1000 * RESP_MAX_MS;
  localparam int unsigned MEAS_TENTH_MS = 100;
  localparam int unsigned MEAS_TENTH_CYC = CLK_HZ / 1000 * MEAS_TENTH_MS;
  localparam int unsigned MEAS_TIME_MAX = 999;
  localparam int unsigned SAMPLE_DIV_DEF = 250;
  // work storage
  localparam int unsigned WORKS = 16;
  localparam int unsigned CFG_WORDS = 7;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CFG_FIRST = 8'h04;
  localparam logic [7:0] OFS_CFG_LAST = 8'h1c;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_EXTREMES = 8'h24;
  localparam logic [31:0] CTRL_MASK = 32'h0000_0f0f;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] CFG_MASK [CFG_WORDS] = '{32'h0000_0f17, 32'h00ff_1f1f,
    32'hffff_ffff, 32'h03ff_ffff, 32'hffff_ffff, 32'hffff_ffff, 32'h0000_ffff};
  localparam logic [31:0] CFG_RST [CFG_WORDS] = '{32'h0000_0000, 32'h0000_0101,
    32'h0000_0000, 32'h0064_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};

  typedef enum logic [2:0] {
    HM_TRACK = 3'b000,
    HM_SAMPLE = 3'b001,
    HM_PEAK = 3'b010,
    HM_SLOPE = 3'b011,
    HM_SWING = 3'b100
  } hold_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_MEAS = 2'b01,
    ST_JUDGE = 2'b10
  } meas_state_t;

  // one work entry, config word 6 first down to word 0
  typedef struct packed {
    logic [15:0] rsv6;
    logic signed [15:0] deadband_width;
    logic signed [15:0] deep_alarm_limit;
    logic signed [15:0] top_alarm_limit;
    logic signed [15:0] bottom_limit;
    logic signed [15:0] upper_limit;
    logic [5:0] rsv3;
    logic [9:0] meas_time;
    logic [15:0] swing_level;
    logic signed [15:0] slope_change_threshold;
    logic signed [15:0] detect_start;
    logic [7:0] rsv1b;
    logic [7:0] swing_scale;
    logic [2:0] rsv1a;
    logic [4:0] win_b;
    logic [2:0] rsv1;
    logic [4:0] win_a;
    logic [19:0] rsv0;
    logic deep_en;
    logic top_en;
    logic const_judge;
    logic crit_load;
    logic [2:0] rsv0b;
    logic swing_min;
    logic rsv0c;
    hold_mode_t mode;
  } work_cfg_t;

  typedef struct packed {
    logic signed [15:0] upper_limit;
    logic signed [15:0] bottom_limit;
    logic signed [15:0] top_alarm_limit;
    logic signed [15:0] deep_alarm_limit;
    logic signed [15:0] deadband_width;
    logic top_en;
    logic deep_en;
    logic hyst_en;
  } limits_t;

  typedef struct packed {
    logic upper;
    logic bottom;
    logic top_alarm;
    logic deep_alarm;
  } judge_t;
endpackage : hold_pkg

// file: hw/limit_judge.sv
`timescale 1ns/1ns
module limit_judge import hold_pkg::*; (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control
  input wire logic update,
  input wire logic clear,
  // value and limits
  input wire logic signed [15:0] value,
  input wire limits_t lim,
  // results
  output judge_t res_q
);
  judge_t res_d;
  wire logic signed [16:0] v17 = 17'(value);
  wire logic hy = lim.hyst_en & (lim.deadband_width != 16'h0000);
  wire logic signed [16:0] up_rel = 17'(lim.upper_limit) - 17'(lim.deadband_width);
  wire logic signed [16:0] lo_rel = 17'(lim.bottom_limit) + 17'(lim.deadband_width);
  wire logic signed [16:0] top_rel = 17'(lim.top_alarm_limit) - 17'(lim.deadband_width);
  wire logic signed [16:0] deep_rel = 17'(lim.deep_alarm_limit) + 17'(lim.deadband_width);
  // plain comparisons
  wire logic b_up = value > lim.upper_limit;
  wire logic b_lo = value < lim.bottom_limit;
  wire logic b_top = lim.top_en & (value > lim.top_alarm_limit);
  wire logic b_deep = lim.deep_en & (value < lim.deep_alarm_limit);
  // deadband keeps a set result, plain opposite result wins
  wire logic k_up = hy & res_q.upper & (v17 >= up_rel);
  wire logic k_lo = hy & res_q.bottom & (v17 <= lo_rel);
  wire logic k_top = hy & lim.top_en & res_q.top_alarm & (v17 >= top_rel);
  wire logic k_deep = hy & lim.deep_en & res_q.deep_alarm & (v17 <= deep_rel);

  assign res_d.upper = b_up | (k_up & ~b_lo);
  assign res_d.bottom = b_lo | (k_lo & ~b_up);
  assign res_d.top_alarm = b_top | (k_top & ~b_lo);
  assign res_d.deep_alarm = b_deep | (k_deep & ~b_up);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      res_q <= '0;
    end else if (clear) begin
      res_q <= '0;
    end else if (update) begin
      res_q <= res_d;
    end
  end

  property p_alarm_off;
    @(posedge hclk) disable iff (!hresetn)
    update && !clear && !lim.top_en |=> !res_q.top_alarm;
  endproperty
  a_alarm_off: assert property (p_alarm_off) else $error("disabled alarm asserted");

  property p_upper_set;
    @(posedge hclk) disable iff (!hresetn)
    update && !clear && (value > lim.upper_limit) |=> res_q.upper && !res_q.bottom;
  endproperty
  a_upper_set: assert property (p_upper_set) else $error("upper result missing");

  property p_deadband_keep;
    @(posedge hclk) disable iff (!hresetn)
    update && !clear && hy && res_q.upper && !b_lo && (v17 >= up_rel) |=> res_q.upper;
  endproperty
  a_deadband_keep: assert property (p_deadband_keep) else $error("upper dropped early");
endmodule : limit_judge

// file: bench/ctrl_model.sv
`timescale 1ns/1ns
module ctrl_model #(
  parameter int unsigned HOLD_CYC = 12
) (
  // clock
  input wire logic hclk,
  // pins toward the block
  output logic start_in,
  output logic hold_cmd_in
);
  initial begin
    start_in = 1'b0;
    hold_cmd_in = 1'b0;
  end

  task automatic begin_meas();
    @(posedge hclk);
    start_in <= 1'b1;
  endtask : begin_meas

  task automatic end_meas();
    @(posedge hclk);
    start_in <= 1'b0;
  endtask : end_meas

  // pulse kept long enough to pass the input synchroniser
  task automatic hold_pulse();
    @(posedge hclk);
    hold_cmd_in <= 1'b1;
    repeat (HOLD_CYC) @(posedge hclk);
    hold_cmd_in <= 1'b0;
  endtask : hold_pulse
endmodule : ctrl_model

// file: bench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import hold_pkg::*;
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hready;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic signed [15:0] load_in;
  logic start_in;
  logic hold_cmd_in;
  judge_t judge_out;
  logic judge_done_out;
  logic meas_done_out;
  logic signed [15:0] held_out;
  int err_count;
  int checked;
  int seed;
  logic [31:0] rd;
  logic signed [15:0] mx;
  logic signed [15:0] v;
  logic [31:0] modes [6] = '{32'h0d02, 32'h0902, 32'h0d02, 32'h0502, 32'h0d04, 32'h0d14};
  int los [6] = '{0, 0, -300, -300, 0, 0};
  int spans [6] = '{1000, 1000, 150, 150, 400, 400};
  logic signed [15:0] slope_v [5] = '{16'sd90, 16'sd550, 16'sd560, 16'sd700, 16'sd800};

  load_hold_judge #(.SAMPLE_DIV(4), .TENTH_CYC(20), .HIST_DEPTH(64)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .load_in(load_in), .start_in(start_in),
    .hold_cmd_in(hold_cmd_in), .judge_out(judge_out), .judge_done_out(judge_done_out),
    .meas_done_out(meas_done_out), .held_out(held_out));
  ctrl_model #(.HOLD_CYC(12)) u_ctrl (.hclk(hclk), .start_in(start_in),
    .hold_cmd_in(hold_cmd_in));
  assign hready = hreadyout;

  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  task automatic finish_test();
    $display("counts: %0d compared, %0d mismatches", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic timeout();
    err_count++;
    $display("timeout at %0t", $time);
    finish_test();
  endtask : timeout

  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) timeout();
  endtask : wait_ready

  task automatic ahb(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
  endtask : ahb

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    ahb(a, 1'b1, d);
  endtask : wr

  task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
    ahb(a, 1'b0, 32'h0);
    check(rd, exp);
    check({31'h0, hresp}, 32'h0);
  endtask : rchk

  task automatic wait_done(input logic lvl);
    int n;
    n = 0;
    while (meas_done_out !== lvl && n < 60) begin
      @(posedge hclk);
      n++;
    end
    if (meas_done_out !== lvl) timeout();
  endtask : wait_done

  function automatic logic [31:0] exp_judge(logic signed [15:0] x, logic [31:0] mw);
    return {28'h0, x > 16'sd500, x < 16'sd100, mw[10] && x > 16'sd900, mw[11] && x < -16'sd100};
  endfunction : exp_judge

  initial begin
    seed = 35353;
    err_count = 0;
    checked = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    load_in = 16'sh0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    rchk(32'h08, 32'h0000_0101);
    rchk(32'h10, 32'h0064_0000);
    rchk(32'h40, 32'h0000_0000);
    wr(32'h04, 32'hffff_ffff);
    rchk(32'h04, 32'h0000_0f17);
    wr(32'h00, 32'h0000_0303);
    wr(32'h08, 32'h0001_0101);
    wr(32'h10, 32'h0064_0064);
    wr(32'h14, 32'h0064_01f4);
    wr(32'h18, 32'hff9c_0384);
    wr(32'h00, 32'h0000_0003);
    rchk(32'h14, 32'h0000_0000);
    wr(32'h00, 32'h0000_0303);
    $display("register test done");
    // peak and swing runs, each restart clears the last verdict
    for (int i = 0; i < 6; i++) begin
      wr(32'h04, modes[i]);
      load_in <= 16'(los[i]);
      u_ctrl.begin_meas();
      wait_done(1'b0);
      check({28'h0, judge_out}, 32'h0);
      check({31'h0, judge_done_out}, 32'h0);
      repeat (12) @(posedge hclk);
      mx = 16'(los[i]);
      for (int j = 0; j < 6; j++) begin
        v = (j == 0) ? 16'(los[i] + spans[i] - 1) : 16'(los[i] + ({$random(seed)} % spans[i]));
        if (v > mx) mx = v;
        load_in <= v;
        repeat (8) @(posedge hclk);
      end
      load_in <= 16'(los[i]);
      repeat (8) @(posedge hclk);
      u_ctrl.end_meas();
      wait_done(1'b1);
      if (modes[i][4]) mx = 16'(los[i]);
      check({16'h0, held_out}, {16'h0, mx});
      check({28'h0, judge_out}, exp_judge(mx, modes[i]));
      check({31'h0, judge_done_out}, 32'h1);
    end
    $display("peak and swing test done");
    // sampled mode: only the first hold edge counts
    wr(32'h04, 32'h0000_0d01);
    load_in <= 16'sd123;
    u_ctrl.begin_meas();
    wait_done(1'b0);
    repeat (12) @(posedge hclk);
    u_ctrl.hold_pulse();
    check({16'h0, held_out}, 32'h0000_007b);
    load_in <= 16'sd456;
    repeat (8) @(posedge hclk);
    u_ctrl.hold_pulse();
    check({16'h0, held_out}, 32'h0000_007b);
    u_ctrl.end_meas();
    wait_done(1'b1);
    check({28'h0, judge_out}, exp_judge(16'sd123, 32'h0d01));
    $display("sampled test done");
    // tracking mode follows the live load
    wr(32'h04, 32'h0000_0d00);
    u_ctrl.begin_meas();
    wait_done(1'b0);
    for (int j = 0; j < 3; j++) begin
      v = 16'(({$random(seed)} % 2000) - 1000);
      load_in <= v;
      repeat (12) @(posedge hclk);
      check({16'h0, held_out}, {16'h0, v});
    end
    u_ctrl.end_meas();
    wait_done(1'b1);
    $display("tracking test done");
    // slope break: steep step below start load ignored, step into 700 is the break
    wr(32'h0c, 32'h0032_0064);
    wr(32'h04, 32'h0000_0d03);
    load_in <= 16'sd0;
    u_ctrl.begin_meas();
    wait_done(1'b0);
    repeat (12) @(posedge hclk);
    for (int j = 0; j < 5; j++) begin
      load_in <= slope_v[j];
      repeat (8) @(posedge hclk);
    end
    u_ctrl.end_meas();
    wait_done(1'b1);
    check({16'h0, held_out}, 32'h0000_0230);
    check({28'h0, judge_out}, exp_judge(16'sd560, 32'h0d03));
    $display("slope test done");
    // constant judgment on the live load with a deadband of 50
    wr(32'h1c, 32'h0000_0032);
    wr(32'h04, 32'h0000_0300);
    load_in <= 16'sd600;
    u_ctrl.begin_meas();
    wait_done(1'b0);
    repeat (16) @(posedge hclk);
    check({28'h0, judge_out}, 32'h8);
    load_in <= 16'sd470;
    repeat (16) @(posedge hclk);
    check({28'h0, judge_out}, 32'h8);
    load_in <= 16'sd400;
    repeat (16) @(posedge hclk);
    check({28'h0, judge_out}, 32'h0);
    u_ctrl.end_meas();
    wait_done(1'b1);
    $display("deadband test done");
    // no criterion, run ended by the measuring time
    wr(32'h04, 32'h0000_0002);
    wr(32'h10, 32'h0001_0064);
    load_in <= 16'sd950;
    u_ctrl.begin_meas();
    wait_done(1'b0);
    wait_done(1'b1);
    check({28'h0, judge_out}, 32'h0);
    check({31'h0, judge_done_out}, 32'h0);
    u_ctrl.end_meas();
    $display("no criterion test done");
    finish_test();
  end
endmodule : tb_top
